// File: common/eeprom_pkg.sv
/*
 * Constants shared by the two-wire EEPROM access logic: array geometry,
 * address byte layout, link bit counts and program cycle timing.
 * Assumes a 125 MHz core clock that oversamples the link clock.
 */
package eeprom_pkg;
    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int unsigned ARRAY_BYTES    = 512;
    localparam int unsigned ADDR_W         = 9;
    localparam int unsigned PAGE_BYTES     = 16;
    localparam int unsigned PAGE_LOW_W     = 4;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    // ----------------------------------------------------------------
    // Device address byte layout
    // ----------------------------------------------------------------
    localparam logic [3:0]  TYPE_ID        = 4'h5;  // Arbitrary value
    localparam int unsigned TYPE_ID_HI     = 7;
    localparam int unsigned TYPE_ID_LO     = 4;
    localparam int unsigned SEL_HIGH_BIT   = 3;
    localparam int unsigned SEL_LOW_BIT    = 2;
    localparam int unsigned ADDR_MSB_BIT   = 1;
    localparam int unsigned RW_BIT         = 0;

    // ----------------------------------------------------------------
    // Link framing
    // ----------------------------------------------------------------
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam int unsigned FIFO_DEPTH     = 4;

    // ----------------------------------------------------------------
    // Program cycle time
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ             = 125;
    localparam int unsigned PROGRAM_CYCLE_US    = 5000;
    localparam int unsigned PROGRAM_CYCLE_TICKS = PROGRAM_CYCLE_US * CLK_MHZ;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b0000001,
        ST_DEVADDR = 7'b0000010,
        ST_WORD    = 7'b0000100,
        ST_WDATA   = 7'b0001000,
        ST_RDATA   = 7'b0010000,
        ST_RACK    = 7'b0100000,
        ST_IGNORE  = 7'b1000000
    } link_state_t;
endpackage

// File: core/byte_fifo.sv
/*
 * Small valid/ready FIFO holding page bytes between the link and the
 * array. Assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("byte_fifo depth must be a power of two");
        end
    end

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0]   count;
    } fifo_state_t;

    fifo_state_t       st_reg;
    fifo_state_t       st_next;
    logic [WIDTH-1:0]  mem [DEPTH];
    logic              push;
    logic              pop;

    assign in_ready  = (st_reg.count != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (st_reg.count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = st_reg.wr_ptr + PW'(1);
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + PW'(1);
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + (PW+1)'(1);
        end else if (pop && !push) begin
            st_next.count = st_reg.count - (PW+1)'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st_reg.wr_ptr] <= in_data;
        end
        // Bypass: a byte pushed into the head slot is not yet in storage
        if (push && (st_next.rd_ptr == st_reg.wr_ptr)) begin
            out_data <= in_data;
        end else begin
            out_data <= mem[st_next.rd_ptr];
        end
    end
endmodule
`default_nettype wire

// File: core/eeprom_access.sv
/*
 * Two-wire serial EEPROM access logic: link decode, byte and page write,
 * self-timed program cycle with busy refusal, and current, random and
 * sequential reads. Assumes link clock and data arrive unsynchronised
 * and are oversampled by core_clk; the data pin is open drain.
 */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access
    import eeprom_pkg::*;
#(
    parameter int unsigned PROGRAM_TICKS = PROGRAM_CYCLE_TICKS
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic link_clk,
    input  wire logic link_data_in,
    output logic      link_data_out,
    output logic      link_data_oe,
    input  wire logic select_pin_high,
    input  wire logic select_pin_low,
    input  wire logic write_protect,
    output logic      program_busy
);
    initial begin
        if (PROGRAM_TICKS < 1) begin
            $error("program cycle must last at least one tick");
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]        scl_sync;
        logic [1:0]        sda_sync;
        logic [1:0]        sel_sync;
        logic [1:0]        wp_sync;
        logic              scl_prev;
        logic              sda_prev;
        link_state_t       state;
        logic [3:0]        bit_cnt;
        logic [7:0]        shift;
        logic              in_ack;
        logic              drive_low;
        logic [ADDR_W-1:0] addr;
        logic              addr_msb;
        logic              wrote_data;
        logic              busy;
        logic              wp_latched;
        logic [31:0]       timer;
        logic              drain;
        logic [ADDR_W-1:0] prog_addr;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    logic [7:0]  array_mem [ARRAY_BYTES];
    logic [7:0]  rd_byte;

    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [7:0]  fifo_in_data;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;

    // Page bytes queue here; a fifth byte finds the queue full and is refused
    // without an acknowledge, and the queue drains during the program cycle
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_page_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    function automatic logic dev_match(input logic [7:0] b, input logic [1:0] sel);
        dev_match = (b[TYPE_ID_HI:TYPE_ID_LO] == TYPE_ID) && (b[SEL_HIGH_BIT] == sel[1])
                    && (b[SEL_LOW_BIT] == sel[0]);
    endfunction

    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_LOW_W], a[PAGE_LOW_W-1:0] + PAGE_LOW_W'(1)};
    endfunction

    // Select low strap has its own two-flop synchroniser outside the state
    logic [1:0] sel_low_sync;
    logic       select_low_q;
    assign select_low_q = sel_low_sync[1];

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl        = st_reg.scl_sync[1];
    assign sda        = st_reg.sda_sync[1];
    assign scl_rise   = scl && !st_reg.scl_prev;
    assign scl_fall   = !scl && st_reg.scl_prev;
    assign start_cond = scl && st_reg.scl_prev && st_reg.sda_prev && !sda;
    assign stop_cond  = scl && st_reg.scl_prev && !st_reg.sda_prev && sda;

    assign link_data_out = 1'b0;
    assign link_data_oe  = st_reg.drive_low;
    assign program_busy  = st_reg.busy;
    assign rd_byte       = array_mem[st_reg.addr];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        fifo_in_valid = 1'b0;
        fifo_in_data  = st_reg.shift;
        st_next.scl_sync = {st_reg.scl_sync[0], link_clk};
        st_next.sda_sync = {st_reg.sda_sync[0], link_data_in};
        st_next.sel_sync = {st_reg.sel_sync[0], select_pin_high};
        st_next.wp_sync  = {st_reg.wp_sync[0], write_protect};
        st_next.scl_prev = scl;
        st_next.sda_prev = sda;
        // Drain also runs without busy: a protected write must empty the queue
        // so that the next write is not refused by a full queue
        fifo_out_ready = st_reg.drain;
        if (!st_reg.busy && st_reg.drain && !fifo_out_valid) begin
            st_next.drain = 1'b0;
        end

        if (st_reg.busy) begin
            // Program cycle: link ignored, bytes drain into the row
            st_next.drive_low = 1'b0;
            st_next.state = ST_IDLE;
            if (fifo_out_ready && fifo_out_valid) begin
                st_next.prog_addr = page_inc(st_reg.prog_addr);
            end
            if (st_reg.timer > 32'd1) begin
                st_next.timer = st_reg.timer - 32'd1;
            end else if (!fifo_out_valid) begin
                st_next.busy  = 1'b0;
                st_next.drain = 1'b0;
            end
        end else if (start_cond) begin
            st_next.state     = ST_DEVADDR;
            st_next.bit_cnt   = '0;
            st_next.in_ack    = 1'b0;
            st_next.drive_low = 1'b0;
        end else if (stop_cond) begin
            st_next.state     = ST_IDLE;
            st_next.drive_low = 1'b0;
            if (st_reg.wrote_data) begin
                st_next.wp_latched = st_reg.wp_sync[1];
                st_next.wrote_data = 1'b0;
                st_next.drain = 1'b1;
                if (!st_reg.wp_sync[1]) begin
                    st_next.busy  = 1'b1;
                    st_next.timer = PROGRAM_TICKS;
                end
            end
        end else if (scl_rise && !st_reg.in_ack) begin
            if (st_reg.state != ST_IDLE && st_reg.state != ST_IGNORE && st_reg.state != ST_RDATA) begin
                st_next.shift   = {st_reg.shift[6:0], sda};
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end else if (st_reg.state == ST_RDATA) begin
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end
        end else if (scl_rise && st_reg.in_ack && st_reg.state == ST_RACK) begin
            // Counter moves past the byte just read, even when the read ends
            st_next.addr = st_reg.addr + ADDR_W'(1);
            if (sda) begin
                st_next.state = ST_IDLE;
            end else begin
                st_next.state = ST_RDATA;
            end
        end else if (scl_fall) begin
            if (st_reg.in_ack) begin
                st_next.in_ack    = 1'b0;
                st_next.drive_low = 1'b0;
                st_next.bit_cnt   = '0;
                if (st_reg.state == ST_RDATA) begin
                    st_next.drive_low = !rd_byte[7];
                end
            end else if (st_reg.state == ST_RDATA) begin
                if (st_reg.bit_cnt == BITS_PER_BYTE) begin
                    st_next.drive_low = 1'b0;
                    st_next.in_ack    = 1'b1;
                    st_next.state     = ST_RACK;
                end else begin
                    st_next.drive_low = !rd_byte[3'd7 - st_reg.bit_cnt[2:0]];
                end
            end else if (st_reg.bit_cnt == BITS_PER_BYTE) begin
                st_next.in_ack = 1'b1;
                case (st_reg.state)
                    ST_DEVADDR: begin
                        if (dev_match(st_reg.shift, {st_reg.sel_sync[1], select_low_q})) begin
                            st_next.drive_low = 1'b1;
                            if (st_reg.shift[RW_BIT]) begin
                                st_next.state = ST_RDATA;
                            end else begin
                                st_next.addr_msb = st_reg.shift[ADDR_MSB_BIT];
                                st_next.state    = ST_WORD;
                            end
                        end else begin
                            st_next.state = ST_IGNORE;
                        end
                    end
                    ST_WORD: begin
                        st_next.drive_low = 1'b1;
                        st_next.addr      = {st_reg.addr_msb, st_reg.shift};
                        st_next.prog_addr = {st_reg.addr_msb, st_reg.shift};
                        st_next.state     = ST_WDATA;
                    end
                    ST_WDATA: begin
                        // Beyond the queue depth a byte is refused with no acknowledge
                        st_next.drive_low = fifo_in_ready;
                        fifo_in_valid     = 1'b1;
                        st_next.wrote_data = 1'b1;
                        st_next.addr      = page_inc(st_reg.addr);
                    end
                    default: begin
                        st_next.state = ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Strap synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sel_low_sync <= 2'h0;
        end else begin
            sel_low_sync <= {sel_low_sync[0], select_pin_low};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg       <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.scl_sync <= 2'h3;
            st_reg.sda_sync <= 2'h3;
            st_reg.scl_prev <= 1'b1;
            st_reg.sda_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Array
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < ARRAY_BYTES; i++) begin
            array_mem[i] = ERASED_BYTE;
        end
    end

    // Only a real program cycle writes; a protected drain discards bytes
    always_ff @(posedge core_clk) begin
        if (st_reg.busy && fifo_out_ready && fifo_out_valid) begin
            array_mem[st_reg.prog_addr] <= fifo_out_data;
        end
    end
endmodule
`default_nettype wire

// File: sim/link_master.sv
/* Two-wire bus master model: makes the link clock and pulls data low.
   Assumes a pulled-up data wire resolved in the bench. */
`timescale 1ns/1ps
`default_nettype none
module link_master (
    input  wire logic core_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------------------------
    // Bit timing: quarter bit of 5 core cycles, 160 ns link clock
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tq(input int n);
        repeat (n * 5) @(posedge core_clk);
    endtask
    // Also serves as repeated start, so dummy writes need no stop
    task automatic start();
        sda_low <= 1'b0;
        tq(1);
        scl <= 1'b1;
        tq(1);
        sda_low <= 1'b1;
        tq(1);
        scl <= 1'b0;
        tq(1);
    endtask
    // Clock is left high afterwards: it stands still between frames
    task automatic stop();
        sda_low <= 1'b1;
        tq(1);
        scl <= 1'b1;
        tq(1);
        sda_low <= 1'b0;
        tq(2);
    endtask
    task automatic bit_out(input logic b);
        sda_low <= !b;
        tq(1);
        scl <= 1'b1;
        tq(2);
        scl <= 1'b0;
        tq(1);
    endtask
    task automatic bit_in(output logic b);
        sda_low <= 1'b0;
        tq(1);
        scl <= 1'b1;
        tq(1);
        b = sda;
        tq(1);
        scl <= 1'b0;
        tq(1);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = !b;
    endtask
    task automatic recv_byte(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(!ack);
    endtask
endmodule
`default_nettype wire

// File: sim/eeprom_access_asserts.sv
/* Port checks on the access logic.
   Assumes the bind below and a master that keeps protect steady at stop. */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_asserts
    import eeprom_pkg::*;
#(
    parameter int unsigned PROGRAM_TICKS = PROGRAM_CYCLE_TICKS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic link_data_in,
    input wire logic link_data_out,
    input wire logic link_data_oe,
    input wire logic select_pin_high,
    input wire logic select_pin_low,
    input wire logic write_protect,
    input wire logic program_busy
);
    // ------------------------------------------------------------
    // Program cycle length counter
    // ------------------------------------------------------------
    logic [31:0] busy_len_reg;
    always_ff @(posedge core_clk) begin
        if (reset || !program_busy) busy_len_reg <= '0;
        else busy_len_reg <= busy_len_reg + 32'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_out_low: assert property (link_data_out == 1'b0)
        else $error("data pin driven high");
    a_busy_silent: assert property (program_busy |-> !link_data_oe)
        else $error("acknowledge while programming");
    // One cycle of slack: the exact edge of the count is the design's choice
    a_busy_min: assert property ($fell(program_busy) |-> busy_len_reg >= PROGRAM_TICKS - 1)
        else $error("program cycle too short");
    a_busy_hold: assert property ($rose(program_busy) |=> program_busy [*8])
        else $error("program cycle collapsed");
    a_busy_at_stop: assert property ($rose(program_busy) |-> link_clk && link_data_in)
        else $error("program cycle without stop");
    a_protect_gate: assert property ($rose(program_busy) |-> !$past(write_protect, 6))
        else $error("programming while protected");
    a_oe_clk_low: assert property ($changed(link_data_oe) |-> !link_clk)
        else $error("data changed while clock high");
    a_oe_release: assert property ($rose(link_data_oe) |-> ##[1:220] !link_data_oe)
        else $error("data pin held too long");
endmodule
bind eeprom_access eeprom_access_asserts #(.PROGRAM_TICKS(PROGRAM_TICKS)) checks (
    .core_clk(core_clk), .reset(reset), .link_clk(link_clk), .link_data_in(link_data_in),
    .link_data_out(link_data_out), .link_data_oe(link_data_oe), .select_pin_high(select_pin_high),
    .select_pin_low(select_pin_low), .write_protect(write_protect), .program_busy(program_busy));
`default_nettype wire

// File: sim/serial_eeprom_access_logic_tb.sv
/* Self-checking bench: master model, shadow array, random traffic.
   Assumes a shortened program cycle and a pulled-up data wire. */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_access_logic_tb
    import eeprom_pkg::*;
;
    localparam int unsigned TICKS = 300;
    logic       core_clk;
    logic       reset;
    logic       scl;
    logic       sda_low;
    logic       sel_high;
    logic       sel_low;
    logic       protect;
    logic       data_out;
    logic       data_oe;
    logic       busy;
    logic [8:0] cur;
    logic [7:0] mem [ARRAY_BYTES];
    int         errors;
    int         check_count;
    wire        sda = !(sda_low || (data_oe && !data_out));
    always #4 core_clk = !core_clk;
    eeprom_access #(.PROGRAM_TICKS(TICKS)) DUT (.core_clk(core_clk), .reset(reset), .link_clk(scl),
        .link_data_in(sda), .link_data_out(data_out), .link_data_oe(data_oe), .select_pin_high(sel_high),
        .select_pin_low(sel_low), .write_protect(protect), .program_busy(busy));
    link_master master (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // ------------------------------------------------------------
    // Checks, expectations and operations
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dev(input logic rw, input logic msb);
        return {TYPE_ID, sel_high, sel_low, msb, rw};
    endfunction
    function automatic logic [8:0] page_step(input logic [8:0] a);
        return {a[8:4], a[3:0] + 4'h1};
    endfunction
    task automatic poll();
        logic ack;
        master.stop();
        for (int i = 0; i < 12; i++) begin
            master.start();
            master.send_byte(dev(1'b0, 1'b0), ack);
            if (ack) return;
            master.stop();
        end
        errors++;
        tally_and_finish();
    endtask
    task automatic op_write(input logic [8:0] a, input int n, input logic flip);
        logic       ack;
        logic       prot;
        logic [7:0] d;
        prot = protect;
        master.start();
        master.send_byte(dev(1'b0, a[8]), ack);
        check1(ack, 1'b1);
        master.send_byte(a[7:0], ack);
        check1(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            master.send_byte(d, ack);
            check1(ack, 1'(i < FIFO_DEPTH));
            if (i < FIFO_DEPTH && !prot) mem[a] = d;
            a = page_step(a);
        end
        master.stop();
        repeat (8) @(posedge core_clk);
        check1(busy, !prot);
        if (flip) protect <= !protect;
        master.start();
        master.send_byte(dev(1'b0, 1'b0), ack);
        check1(ack, prot);
        if (!ack) poll();
    endtask
    task automatic op_read(input logic [8:0] a, input int n, input logic rnd);
        logic       ack;
        logic [7:0] d;
        if (rnd) begin
            master.start();
            master.send_byte(dev(1'b0, a[8]), ack);
            master.send_byte(a[7:0], ack);
        end else a = cur;
        master.start();
        master.send_byte(dev(1'b1, 1'($urandom)), ack);
        check1(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            master.recv_byte(d, i < n - 1);
            check8(d, mem[a]);
            a = a + 9'h1;
        end
        cur = a;
        master.stop();
    endtask
    initial begin
        logic       ack;
        logic [8:0] a;
        core_clk = 1'b0;
        reset = 1'b1;
        sel_high = 1'b0;
        sel_low = 1'b0;
        protect = 1'b0;
        errors = 0;
        check_count = 0;
        for (int i = 0; i < ARRAY_BYTES; i++) mem[i] = ERASED_BYTE;
        void'($urandom(32'hF581E51E));
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        sel_high <= 1'($urandom);
        sel_low <= 1'($urandom);
        repeat (4) @(posedge core_clk);
        op_read(9'($urandom), 2, 1'b1);
        for (int k = 0; k < 3; k++) begin
            master.start();
            master.send_byte(dev(1'b1, 1'b0) ^ (8'h04 << k), ack);
            check1(ack, 1'b0);
            master.stop();
        end
        a = 9'($urandom);
        op_write(a, 1, 1'b0);
        op_read(a, 1, 1'b1);
        a = {a[8:4], 4'hE};
        op_write(a, 5, 1'b0);
        op_read({a[8:4], 4'h0}, 16, 1'b1);
        protect <= 1'b1;
        @(posedge core_clk);
        op_write(a, 3, 1'b0);
        protect <= 1'b0;
        @(posedge core_clk);
        op_write(9'h1FE, 1, 1'b1);
        protect <= 1'b0;
        @(posedge core_clk);
        op_read(9'h1FD, 4, 1'b1);
        op_read(9'h000, 2, 1'b0);
        for (int r = 0; r < 6; r++) begin
            a = 9'($urandom);
            op_write(a, 1 + ($urandom % 5), 1'b0);
            op_read(a, 1, 1'b1);
        end
        tally_and_finish();
    end
    // Hang guard: a stuck handshake ends the run as a failure
    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
